// >>> verilog/ufc_regs.sv
// Function control register bank and its link-side command handling.
// Assumes the link follows the register command sequences and obeys the direction pin.
`timescale 1ns/1ps
module ufc_regs #(
  parameter logic [7:0] PRODUCT_UPPER = ufc_pkg::PRODUCT_UPPER_DEFAULT, // Arbitrary value
  parameter int RESET_EDGES = ufc_pkg::CORE_RESET_EDGES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic link_clk_in,
  input wire logic stp_in,
  input wire logic [7:0] data_in,
  input wire logic plus_line_pulldown_in,
  input wire logic minus_line_pulldown_in,
  output logic [7:0] data_out,
  output logic data_oe_n_out,
  output logic dir_out,
  output logic nxt_out,
  output logic low_power_out,
  output logic core_reset_out,
  output logic hs_xcvr_en_out,
  output logic fs_xcvr_en_out,
  output logic ls_xcvr_en_out,
  output logic fs_preamble_out,
  output logic non_driving_out,
  output logic raw_encoding_out,
  output logic no_sync_eop_out,
  output logic fs_pullup_en_out,
  output logic hs_term_en_out
);
  // ==========================================================================
  // Pin sampling
  logic strobe;
  logic stp_s;
  logic [7:0] data_s;

  ufc_link_sampler #(.WIDTH(8)) u_sampler (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .link_clk_in(link_clk_in),
    .stp_in(stp_in),
    .data_in(data_in),
    .strobe_out(strobe),
    .stp_out(stp_s),
    .data_out(data_s)
  );

  // ==========================================================================
  // Register and sequencer state
  ufc_pkg::ufc_function_control_t ctrl_r, ctrl_nxt;
  ufc_pkg::ufc_state_t st_r, st_nxt;
  logic [5:0] addr_r, addr_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [7:0] dout_nxt;
  logic oe_n_nxt, dir_nxt, nxt_nxt;

  // Read mux; unmapped addresses answer zero
  function automatic logic [7:0] read_reg(input logic [5:0] a, input logic [7:0] fc);
    logic [7:0] v;
    v = ufc_pkg::READ_UNMAPPED;
    if (a == ufc_pkg::ADDR_PRODUCT_UPPER) begin
      v = PRODUCT_UPPER;
    end else if (a == ufc_pkg::ADDR_FC_WRITE || a == ufc_pkg::ADDR_FC_SET || a == ufc_pkg::ADDR_FC_CLEAR) begin
      v = fc & ufc_pkg::FC_WRITE_MASK;
    end
    return v;
  endfunction : read_reg

  // Next-state logic; steps advance on the sampled link strobe, except leaving idle for low power or core reset
  always_comb begin
    ctrl_nxt = ctrl_r;
    st_nxt = st_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    cnt_nxt = cnt_r;
    dout_nxt = data_out;
    oe_n_nxt = data_oe_n_out;
    dir_nxt = dir_out;
    nxt_nxt = nxt_out;
    case (st_r)
      ufc_pkg::S_IDLE: begin
        if (!ctrl_r.low_power_n) begin
          st_nxt = ufc_pkg::S_LOW_POWER;
          dir_nxt = 1'b1;
        end else if (ctrl_r.core_reset) begin
          st_nxt = ufc_pkg::S_CORE_RST;
          dir_nxt = 1'b1;
          cnt_nxt = 8'h00;
        end else if (strobe && data_s[7:6] == ufc_pkg::CMD_REG_WRITE) begin
          addr_nxt = data_s[5:0];
          nxt_nxt = 1'b1;
          st_nxt = ufc_pkg::S_W_DATA;
        end else if (strobe && data_s[7:6] == ufc_pkg::CMD_REG_READ) begin
          addr_nxt = data_s[5:0];
          nxt_nxt = 1'b1;
          st_nxt = ufc_pkg::S_R_TURN;
        end
      end
      ufc_pkg::S_W_DATA: begin
        if (strobe) begin
          nxt_nxt = 1'b0;
          wdata_nxt = data_s;
          // Early stop aborts the write without touching the register
          st_nxt = stp_s ? ufc_pkg::S_IDLE : ufc_pkg::S_W_STOP;
        end
      end
      ufc_pkg::S_W_STOP: begin
        if (strobe && stp_s) begin
          st_nxt = ufc_pkg::S_IDLE;
          case (addr_r)
            ufc_pkg::ADDR_FC_WRITE: ctrl_nxt = wdata_r & ufc_pkg::FC_WRITE_MASK;
            ufc_pkg::ADDR_FC_SET: ctrl_nxt = (ctrl_r | wdata_r) & ufc_pkg::FC_WRITE_MASK;
            ufc_pkg::ADDR_FC_CLEAR: ctrl_nxt = ctrl_r & ~wdata_r & ufc_pkg::FC_WRITE_MASK;
            default: ctrl_nxt = ctrl_r; // Read-only and unmapped: ignored
          endcase
        end
      end
      ufc_pkg::S_R_TURN: begin
        if (strobe) begin
          nxt_nxt = 1'b0;
          dir_nxt = 1'b1; // Turnaround cycle, bus not yet driven
          st_nxt = ufc_pkg::S_R_DRIVE;
        end
      end
      ufc_pkg::S_R_DRIVE, ufc_pkg::S_RX_DRIVE: begin
        if (strobe) begin
          oe_n_nxt = 1'b0;
          dout_nxt = (st_r == ufc_pkg::S_R_DRIVE) ? read_reg(addr_r, ctrl_r) : ufc_pkg::RXCMD_AFTER_RESET;
          st_nxt = ufc_pkg::S_END;
        end
      end
      ufc_pkg::S_END: begin
        if (strobe) begin
          oe_n_nxt = 1'b1;
          dir_nxt = 1'b0;
          st_nxt = ufc_pkg::S_IDLE;
        end
      end
      ufc_pkg::S_CORE_RST: begin
        // Register set is untouched while the core is held in reset, except core_reset cleared on the last counted strobe
        if (strobe) begin
          cnt_nxt = cnt_r + 8'h01;
          if (cnt_r == 8'(RESET_EDGES - 1)) begin
            ctrl_nxt.core_reset = 1'b0;
            dir_nxt = 1'b0;
            st_nxt = ufc_pkg::S_RX_TURN;
          end
        end
      end
      ufc_pkg::S_RX_TURN: begin
        if (strobe) begin
          dir_nxt = 1'b1; // Status byte follows the reset
          st_nxt = ufc_pkg::S_RX_DRIVE;
        end
      end
      ufc_pkg::S_LOW_POWER: begin
        if (strobe && stp_s) begin
          ctrl_nxt.low_power_n = 1'b1;
          dir_nxt = 1'b0;
          st_nxt = ufc_pkg::S_IDLE;
        end
      end
      default: begin
        st_nxt = ufc_pkg::S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_r <= ufc_pkg::FC_RESET_VALUE;
      st_r <= ufc_pkg::S_IDLE;
      addr_r <= 6'h00;
      wdata_r <= 8'h00;
      cnt_r <= 8'h00;
      data_out <= 8'h00;
      data_oe_n_out <= 1'b1;
      dir_out <= 1'b0;
      nxt_out <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      st_r <= st_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      cnt_r <= cnt_nxt;
      data_out <= dout_nxt;
      data_oe_n_out <= oe_n_nxt;
      dir_out <= dir_nxt;
      nxt_out <= nxt_nxt;
    end
  end

  // ==========================================================================
  // Transceiver controls decoded from the register; low power and core reset come from the sequencer state
  logic [10:0] ctl_nxt;
  always_comb begin
    ctl_nxt[0] = (st_r == ufc_pkg::S_LOW_POWER);
    ctl_nxt[1] = (st_r == ufc_pkg::S_CORE_RST);
    ctl_nxt[2] = (ctrl_r.speed_choice == ufc_pkg::SPEED_HIGH);
    ctl_nxt[3] = (ctrl_r.speed_choice == ufc_pkg::SPEED_FULL) ||
                 (ctrl_r.speed_choice == ufc_pkg::SPEED_LOW_ON_FULL);
    ctl_nxt[4] = (ctrl_r.speed_choice == ufc_pkg::SPEED_LOW);
    ctl_nxt[5] = (ctrl_r.speed_choice == ufc_pkg::SPEED_LOW_ON_FULL);
    ctl_nxt[6] = (ctrl_r.tx_encoding_style == ufc_pkg::ENC_NON_DRIVING);
    ctl_nxt[7] = (ctrl_r.tx_encoding_style == ufc_pkg::ENC_RAW);
    ctl_nxt[8] = (ctrl_r.tx_encoding_style == ufc_pkg::ENC_NO_SYNC_EOP);
    // Pull-up only as a peripheral: host pulldowns on the plus line forbid it
    ctl_nxt[9] = ctrl_r.termination_choice && !ctl_nxt[2] && !ctl_nxt[6] && !plus_line_pulldown_in;
    ctl_nxt[10] = !ctrl_r.termination_choice && ctl_nxt[2] && !ctl_nxt[6] &&
                  !(plus_line_pulldown_in && minus_line_pulldown_in && ctrl_r.tx_encoding_style == ufc_pkg::ENC_RAW);
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      {hs_term_en_out, fs_pullup_en_out, no_sync_eop_out, raw_encoding_out, non_driving_out,
       fs_preamble_out, ls_xcvr_en_out, fs_xcvr_en_out, hs_xcvr_en_out, core_reset_out, low_power_out} <= 11'h000;
    end else begin
      {hs_term_en_out, fs_pullup_en_out, no_sync_eop_out, raw_encoding_out, non_driving_out,
       fs_preamble_out, ls_xcvr_en_out, fs_xcvr_en_out, hs_xcvr_en_out, core_reset_out, low_power_out} <= ctl_nxt;
    end
  end

  // ==========================================================================
  // Checks
  chk_reset_values: assert property (@(posedge clk_in) $fell(rst_in) |-> ctrl_r == ufc_pkg::FC_RESET_VALUE)
    else $error("function control reset value wrong");
  chk_set_or: assert property (@(posedge clk_in) disable iff (rst_in)
    (st_r == ufc_pkg::S_W_STOP && strobe && stp_s && addr_r == ufc_pkg::ADDR_FC_SET)
    |=> ctrl_r == (($past(ctrl_r) | $past(wdata_r)) & ufc_pkg::FC_WRITE_MASK))
    else $error("set write did not OR pattern");
  chk_clear_mask: assert property (@(posedge clk_in) disable iff (rst_in)
    (st_r == ufc_pkg::S_W_STOP && strobe && stp_s && addr_r == ufc_pkg::ADDR_FC_CLEAR)
    |=> ctrl_r == ($past(ctrl_r) & ~$past(wdata_r) & ufc_pkg::FC_WRITE_MASK))
    else $error("clear write did not mask");
  chk_reserved_zero: assert property (@(posedge clk_in) disable iff (rst_in) !ctrl_r.reserved)
    else $error("reserved bit set");
  chk_lowpwr_enter: assert property (@(posedge clk_in) disable iff (rst_in)
    (st_r == ufc_pkg::S_IDLE && !ctrl_r.low_power_n) |=> st_r == ufc_pkg::S_LOW_POWER ##1 low_power_out)
    else $error("low power not entered");
  chk_lowpwr_exit: assert property (@(posedge clk_in) disable iff (rst_in)
    (st_r == ufc_pkg::S_LOW_POWER && strobe && stp_s) |=> ctrl_r.low_power_n && st_r == ufc_pkg::S_IDLE ##1 !low_power_out)
    else $error("low power exit did not restore bit");
  chk_reset_dir: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(st_r == ufc_pkg::S_CORE_RST) |-> dir_out ##1 core_reset_out)
    else $error("core reset without direction");
  chk_reset_done: assert property (@(posedge clk_in) disable iff (rst_in)
    $fell(st_r == ufc_pkg::S_CORE_RST) |-> !ctrl_r.core_reset && !dir_out && st_r == ufc_pkg::S_RX_TURN)
    else $error("core reset end wrong");
  chk_read_data: assert property (@(posedge clk_in) disable iff (rst_in)
    (st_r == ufc_pkg::S_R_DRIVE && strobe) |=> !data_oe_n_out && data_out == read_reg(addr_r, ctrl_r))
    else $error("read data wrong");
  chk_turnaround: assert property (@(posedge clk_in) disable iff (rst_in) $rose(dir_out) |-> data_oe_n_out)
    else $error("bus driven on direction rise");
endmodule : ufc_regs

// >>> verilog/ufc_pkg.sv
// Constants, field layouts and state codes of the function control register bank.
// Assumes a single interface clock domain; the link clock is only ever sampled.
package ufc_pkg;
  // ==========================================================================
  // Register addresses on the 6-bit command address field
  localparam logic [5:0] ADDR_PRODUCT_UPPER = 6'h03;
  localparam logic [5:0] ADDR_FC_WRITE = 6'h04;
  localparam logic [5:0] ADDR_FC_SET = 6'h05;
  localparam logic [5:0] ADDR_FC_CLEAR = 6'h06;
  // ==========================================================================
  // Command byte codes in bits 7:6
  localparam logic [1:0] CMD_REG_WRITE = 2'h2;
  localparam logic [1:0] CMD_REG_READ = 2'h3;
  // ==========================================================================
  // Function control values
  localparam logic [7:0] FC_RESET_VALUE = 8'h41;
  localparam logic [7:0] FC_WRITE_MASK = 8'h7f;
  localparam logic [1:0] SPEED_HIGH = 2'h0;
  localparam logic [1:0] SPEED_FULL = 2'h1;
  localparam logic [1:0] SPEED_LOW = 2'h2;
  localparam logic [1:0] SPEED_LOW_ON_FULL = 2'h3;
  localparam logic [1:0] ENC_NORMAL = 2'h0;
  localparam logic [1:0] ENC_NON_DRIVING = 2'h1;
  localparam logic [1:0] ENC_RAW = 2'h2;
  localparam logic [1:0] ENC_NO_SYNC_EOP = 2'h3;
  // ==========================================================================
  // Link-side constants
  localparam int CORE_RESET_EDGES = 8;
  localparam logic [7:0] RXCMD_AFTER_RESET = 8'h00;
  localparam logic [7:0] PRODUCT_UPPER_DEFAULT = 8'h5a; // Arbitrary value
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  typedef struct packed {
    logic reserved;
    logic low_power_n;
    logic core_reset;
    logic [1:0] tx_encoding_style;
    logic termination_choice;
    logic [1:0] speed_choice;
  } ufc_function_control_t;

  typedef enum logic [9:0] {
    S_IDLE = 10'h001,
    S_W_DATA = 10'h002,
    S_W_STOP = 10'h004,
    S_R_TURN = 10'h008,
    S_R_DRIVE = 10'h010,
    S_END = 10'h020,
    S_CORE_RST = 10'h040,
    S_RX_TURN = 10'h080,
    S_RX_DRIVE = 10'h100,
    S_LOW_POWER = 10'h200
  } ufc_state_t;
endpackage : ufc_pkg

// >>> verilog/ufc_link_sampler.sv
// Two-flop synchroniser for the link clock, stop and data pins, with edge finding.
// Assumes the link changes its pins on its rising clock edge.
`timescale 1ns/1ps
module ufc_link_sampler #(
  parameter int WIDTH = 8
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic link_clk_in,
  input wire logic stp_in,
  input wire logic [WIDTH-1:0] data_in,
  output logic strobe_out,
  output logic stp_out,
  output logic [WIDTH-1:0] data_out
);
  // ==========================================================================
  // Synchroniser stages
  logic [WIDTH+1:0] meta_r;
  logic [WIDTH+1:0] sync_r;
  logic clk_prev_r;
  logic strobe_nxt;

  // Sample on the falling link edge, mid-period, where pins are stable
  always_comb begin
    strobe_nxt = clk_prev_r & ~sync_r[WIDTH+1];
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_r <= '0;
      sync_r <= '0;
      clk_prev_r <= 1'b0;
      strobe_out <= 1'b0;
      stp_out <= 1'b0;
      data_out <= '0;
    end else begin
      meta_r <= {link_clk_in, stp_in, data_in};
      sync_r <= meta_r;
      clk_prev_r <= sync_r[WIDTH+1];
      strobe_out <= strobe_nxt;
      stp_out <= sync_r[WIDTH];
      data_out <= sync_r[WIDTH-1:0];
    end
  end
endmodule : ufc_link_sampler

// >>> test/ufc_link_model.sv
// Behavioural link controller on the far side of the register command bus.
// Assumes it is called at a falling edge of the system clock, so link edges never meet its rising edge.
`timescale 1ns/1ps
module ufc_link_model (
  input wire logic dir_in,
  input wire logic [7:0] phy_data_in,
  input wire logic phy_oe_n_in,
  output logic link_clk_out,
  output logic stp_out,
  output logic [7:0] bus_out
);
  logic [7:0] drv;
  logic [7:0] junk;
  // Wire level: device when enabled, link only while it owns the bus, else a changing pattern
  assign bus_out = !phy_oe_n_in ? phy_data_in : (!dir_in ? drv : junk);
  // Clock stands low between frames
  initial begin
    link_clk_out = 1'b0;
    stp_out = 1'b0;
    drv = 8'h00;
    junk = 8'h5a;
  end
  // ==========================================================================
  // One link cycle: pins change on the rise, the device samples on the fall
  task cycle(input logic stp, input logic [7:0] d, output logic [7:0] seen);
    link_clk_out = 1'b1;
    stp_out = stp;
    drv = d;
    junk = ~junk;
    #80;
    link_clk_out = 1'b0;
    seen = bus_out;
    #80;
  endtask : cycle
  // Command, data, then stop to commit; two idle cycles let the sequence settle
  task reg_write(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] s;
    cycle(1'b0, {ufc_pkg::CMD_REG_WRITE, a}, s);
    cycle(1'b0, d, s);
    cycle(1'b1, 8'h00, s);
    cycle(1'b0, 8'h00, s);
    cycle(1'b0, 8'h00, s);
  endtask : reg_write
  // Read data is taken on the fall of the fourth cycle, mid-way through its standing time
  task reg_read(input logic [5:0] a, output logic [7:0] d);
    logic [7:0] s;
    cycle(1'b0, {ufc_pkg::CMD_REG_READ, a}, s);
    cycle(1'b0, 8'h00, s);
    cycle(1'b0, 8'h00, s);
    cycle(1'b0, 8'h00, d);
    cycle(1'b0, 8'h00, s);
  endtask : reg_read
  // Keeps clocking until direction stays low for two cycles; a one-cycle dip is turnaround
  task wait_free(input int limit);
    logic [7:0] s;
    int lows;
    lows = 0;
    for (int n = 0; n < limit && lows < 2; n++) begin
      cycle(1'b0, 8'h00, s);
      lows = dir_in ? 0 : lows + 1;
    end
  endtask : wait_free
endmodule : ufc_link_model

// >>> test/tb_ufc_regs.sv
// Self-checking bench for the function control register bank.
// Assumes the link model drives every link pin; the bench owns reset and the pulldown levels.
`timescale 1ns/1ps
module tb_ufc_regs;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic plus_pd = 1'b0;
  logic minus_pd = 1'b0;
  logic link_clk, stp, data_oe_n, dir, nxt, low_power, core_reset;
  logic [7:0] bus, data_out, rx_val;
  logic hs, fs, ls, pre, nd, raw, nse, fsp, hst;
  logic rx_seen = 1'b0;
  logic rst_seen = 1'b0;
  int num_errors = 0;
  int compares = 0;
  int nxt_hits = 0;
  always #10 clk_in = ~clk_in;
  // Short core reset, yet longer than the two idle write cycles so direction still stands; product byte arbitrary
  ufc_regs #(.PRODUCT_UPPER(8'h3c), .RESET_EDGES(4)) i_dut (.clk_in(clk_in), .rst_in(rst_in),
    .link_clk_in(link_clk), .stp_in(stp), .data_in(bus), .plus_line_pulldown_in(plus_pd),
    .minus_line_pulldown_in(minus_pd), .data_out(data_out), .data_oe_n_out(data_oe_n), .dir_out(dir),
    .nxt_out(nxt), .low_power_out(low_power), .core_reset_out(core_reset), .hs_xcvr_en_out(hs),
    .fs_xcvr_en_out(fs), .ls_xcvr_en_out(ls), .fs_preamble_out(pre), .non_driving_out(nd),
    .raw_encoding_out(raw), .no_sync_eop_out(nse), .fs_pullup_en_out(fsp), .hs_term_en_out(hst));
  ufc_link_model i_link (.dir_in(dir), .phy_data_in(data_out), .phy_oe_n_in(data_oe_n),
    .link_clk_out(link_clk), .stp_out(stp), .bus_out(bus));
  // Status byte, core reset and next as the link would see them on its sampling edge
  always @(negedge link_clk) begin
    if (nxt) begin
      nxt_hits++;
    end
    if (dir && !data_oe_n) begin
      rx_seen = 1'b1;
      rx_val = data_out;
    end
    if (core_reset) begin
      rst_seen = 1'b1;
    end
  end
  // ==========================================================================
  // Shared checks and sequences
  task check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task rd_check(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_link.reg_read(a, d);
    check(16'(d), 16'(exp));
  endtask : rd_check
  task do_reset();
    @(negedge clk_in);
    rst_in = 1'b1;
    repeat (20) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (5) @(negedge clk_in);
  endtask : do_reset
  task complete_run();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  // ==========================================================================
  // Scenarios
  task t_reset_values();
    do_reset();
    check(16'({fs, hs, fsp, low_power, dir, data_oe_n}), 16'(6'b100001));
    rd_check(ufc_pkg::ADDR_PRODUCT_UPPER, 8'h3c);
    for (int a = 4; a < 7; a++) begin
      rd_check(6'(a), ufc_pkg::FC_RESET_VALUE);
    end
    rd_check(6'h10, ufc_pkg::READ_UNMAPPED);
    $display("test reset values done");
  endtask : t_reset_values
  // Bit 7 is set in every pattern; it must never stick
  task t_write_set_clear();
    nxt_hits = 0;
    i_link.reg_write(ufc_pkg::ADDR_FC_WRITE, 8'hda);
    rd_check(ufc_pkg::ADDR_FC_SET, 8'h5a);
    i_link.reg_write(ufc_pkg::ADDR_FC_SET, 8'h84);
    rd_check(ufc_pkg::ADDR_FC_CLEAR, 8'h5e);
    i_link.reg_write(ufc_pkg::ADDR_FC_CLEAR, 8'h8a);
    rd_check(ufc_pkg::ADDR_FC_WRITE, 8'h54);
    i_link.reg_write(ufc_pkg::ADDR_PRODUCT_UPPER, 8'hff);
    rd_check(ufc_pkg::ADDR_PRODUCT_UPPER, 8'h3c);
    check(16'(nxt_hits), 16'h0008);
    $display("test write set clear done");
  endtask : t_write_set_clear
  task t_core_reset();
    rx_seen = 1'b0;
    rst_seen = 1'b0;
    i_link.reg_write(ufc_pkg::ADDR_FC_SET, 8'h20);
    check(16'(dir), 16'(1'b1));
    i_link.wait_free(40);
    check(16'({rst_seen, rx_seen, dir, core_reset}), 16'(4'b1100));
    check(16'(rx_val), 16'(ufc_pkg::RXCMD_AFTER_RESET));
    rd_check(ufc_pkg::ADDR_FC_WRITE, 8'h54);
    $display("test core reset done");
  endtask : t_core_reset
  task t_low_power();
    logic [7:0] s;
    i_link.reg_write(ufc_pkg::ADDR_FC_WRITE, 8'h01);
    check(16'({dir, low_power}), 16'(2'b11));
    i_link.cycle(1'b1, 8'h00, s);
    i_link.wait_free(4);
    check(16'({dir, low_power}), 16'(2'b00));
    rd_check(ufc_pkg::ADDR_FC_WRITE, 8'h41);
    $display("test low power done");
  endtask : t_low_power
  // Every speed and encoding, with termination and pulldowns varied so each term matters
  task t_decode();
    logic [3:0] k;
    logic [1:0] sp;
    logic [1:0] en;
    logic tm;
    logic [8:0] e;
    for (int i = 0; i < 16; i++) begin
      k = 4'(i);
      sp = k[1:0];
      en = k[3:2];
      tm = k[0] ^ k[2];
      plus_pd = (k[1:0] == 2'h0) | k[2];
      minus_pd = k[3];
      i_link.reg_write(ufc_pkg::ADDR_FC_WRITE, {3'b010, en, tm, sp});
      e = {sp == ufc_pkg::SPEED_HIGH, sp[0], sp == ufc_pkg::SPEED_LOW, sp == ufc_pkg::SPEED_LOW_ON_FULL,
        en == ufc_pkg::ENC_NON_DRIVING, en == ufc_pkg::ENC_RAW, en == ufc_pkg::ENC_NO_SYNC_EOP,
        tm & (sp != ufc_pkg::SPEED_HIGH) & (en != ufc_pkg::ENC_NON_DRIVING) & !plus_pd,
        !tm & (sp == ufc_pkg::SPEED_HIGH) & (en != ufc_pkg::ENC_NON_DRIVING)
        & !(plus_pd & minus_pd & (en == ufc_pkg::ENC_RAW))};
      check(16'({hs, fs, ls, pre, nd, raw, nse, fsp, hst}), 16'(e));
    end
    $display("test decode done");
  endtask : t_decode
  // ==========================================================================
  // Main sequence; a second reset at the end of the run checks the register returns to its default
  initial begin
    t_reset_values();
    t_write_set_clear();
    t_core_reset();
    t_low_power();
    t_decode();
    t_reset_values();
    complete_run();
  end
  // Watchdog sized well above the expected run of about 33 us
  initial begin
    #200000;
    num_errors++;
    complete_run();
  end
endmodule : tb_ufc_regs
